// ### rtl/ahb_decode_map.vh
// Memory map, region codes and arbitration constants for the bus decoder
`ifndef AHB_DECODE_MAP_VH
`define AHB_DECODE_MAP_VH
`define REGION_MSB 31
`define REGION_LSB 27
`define RGN_W 5
`define RGN_LOW0 5'h00
`define RGN_LOW1 5'h01
`define RGN_HIGH0 5'h02
`define RGN_HIGH1 5'h03
`define RGN_GP0 5'h04
`define RGN_GP1 5'h05
`define RGN_DISPLAY 5'h06
`define RGN_FLASH2 5'h07
`define RGN_RAM2 5'h08
`define RGN_MODEM_DSP 5'h09
`define RGN_APPS_DSP 5'h0a
`define RGN_TRACE_IO 5'h0b
`define RGN_FAST_BRIDGE 5'h0c
`define RGN_MOTION 5'h0d
`define RGN_LEGACY 5'h10
`define BOOT_SRAM_MSB 31
`define BOOT_SRAM_LSB 16
`define BOOT_SRAM_TAG 16'hffff
`define NSEL 17
`define SEL_FLASH0 0
`define SEL_FLASH1 1
`define SEL_RAM0 2
`define SEL_RAM1 3
`define SEL_GP0 4
`define SEL_GP1 5
`define SEL_DISPLAY 6
`define SEL_FLASH2 7
`define SEL_RAM2 8
`define SEL_MODEM_DSP 9
`define SEL_APPS_DSP 10
`define SEL_TRACE_IO 11
`define SEL_FAST_BRIDGE 12
`define SEL_MOTION 13
`define SEL_LEGACY 14
`define SEL_BOOT_SRAM 15
`define SEL_DEFAULT 16
`define HTRANS_IDLE 2'b00
`define HTRANS_NSEQ 2'b10
`define HTRANS_ACTIVE_BIT 1
`define HRESP_OKAY 2'b00
`define HRESP_ERROR 2'b01
`define LAYER_MAIN 2'b00
`define LAYER_DSP 2'b01
`define LAYER_GFX 2'b10
`endif

// ### rtl/layer_decoder.v
// Combinational address decoder producing one-hot slave selects per layer
`include "ahb_decode_map.vh"
module layer_decoder #(
  parameter [1:0] LAYER = `LAYER_MAIN
) (
  input wire [31:0] haddr,
  input wire boot_nand,
  output reg [`NSEL-1:0] sel
);
  wire [`RGN_W-1:0] rgn;
  reg [`NSEL-1:0] raw;
  reg allowed;
  assign rgn = haddr[`REGION_MSB:`REGION_LSB];

  always @* begin
    raw = {`NSEL{1'b0}};
    if (haddr[`BOOT_SRAM_MSB:`BOOT_SRAM_LSB] == `BOOT_SRAM_TAG) begin
      raw[`SEL_BOOT_SRAM] = 1'b1;
    end else begin
      case (rgn)
        `RGN_LOW0: raw[boot_nand ? `SEL_RAM0 : `SEL_FLASH0] = 1'b1;
        `RGN_LOW1: raw[boot_nand ? `SEL_RAM1 : `SEL_FLASH1] = 1'b1;
        `RGN_HIGH0: raw[boot_nand ? `SEL_FLASH0 : `SEL_RAM0] = 1'b1;
        `RGN_HIGH1: raw[boot_nand ? `SEL_FLASH1 : `SEL_RAM1] = 1'b1;
        `RGN_GP0: raw[`SEL_GP0] = 1'b1;
        `RGN_GP1: raw[`SEL_GP1] = 1'b1;
        `RGN_DISPLAY: raw[`SEL_DISPLAY] = 1'b1;
        `RGN_FLASH2: raw[`SEL_FLASH2] = 1'b1;
        `RGN_RAM2: raw[`SEL_RAM2] = 1'b1;
        `RGN_MODEM_DSP: raw[`SEL_MODEM_DSP] = 1'b1;
        `RGN_APPS_DSP: raw[`SEL_APPS_DSP] = 1'b1;
        `RGN_TRACE_IO: raw[`SEL_TRACE_IO] = 1'b1;
        `RGN_FAST_BRIDGE: raw[`SEL_FAST_BRIDGE] = 1'b1;
        `RGN_MOTION: raw[`SEL_MOTION] = 1'b1;
        `RGN_LEGACY: raw[`SEL_LEGACY] = 1'b1;
        default: raw[`SEL_DEFAULT] = 1'b1;
      endcase
    end
  end

  // Layer reach; anything out of reach lands on the error slave
  always @* begin
    case (LAYER)
      `LAYER_MAIN: allowed = ~raw[`SEL_MOTION];
      default: allowed = raw[`SEL_FLASH0] | raw[`SEL_FLASH1] |
        raw[`SEL_RAM0] | raw[`SEL_RAM1] | raw[`SEL_GP0] | raw[`SEL_GP1] |
        raw[`SEL_DISPLAY] | raw[`SEL_FLASH2] | raw[`SEL_RAM2] |
        (raw[`SEL_MOTION] & (LAYER == `LAYER_DSP));
    endcase
    sel = {`NSEL{1'b0}};
    if (allowed)
      sel = raw;
    else
      sel[`SEL_DEFAULT] = 1'b1;
  end
endmodule // layer_decoder

// ### rtl/multilayer_ahb_decode_arbitration.v
// Three-layer bus arbitration, address decode and default error slave
`include "ahb_decode_map.vh"
module multilayer_ahb_decode_arbitration #(
  parameter MAIN_N = 4,
  parameter DSP_N = 2
) (
  input wire core_clk,
  input wire rst_n,
  input wire boot_mode_pin,
  input wire [MAIN_N-1:0] main_req,
  input wire [31:0] main_haddr,
  input wire [1:0] main_htrans,
  input wire [DSP_N-1:0] dsp_req,
  input wire [31:0] dsp_haddr,
  input wire [1:0] dsp_htrans,
  input wire [31:0] gfx_haddr,
  input wire [1:0] gfx_htrans,
  input wire main_slave_hready,
  input wire dsp_slave_hready,
  input wire gfx_slave_hready,
  output reg [MAIN_N-1:0] main_grant_q,
  output reg [DSP_N-1:0] dsp_grant_q,
  output reg gfx_grant_q,
  output reg [`NSEL-1:0] main_sel_q,
  output reg [`NSEL-1:0] dsp_sel_q,
  output reg [`NSEL-1:0] gfx_sel_q,
  output reg main_hready_q,
  output reg [1:0] main_hresp_q,
  output reg dsp_hready_q,
  output reg [1:0] dsp_hresp_q,
  output reg gfx_hready_q,
  output reg [1:0] gfx_hresp_q,
  output reg boot_nand_q
);
  // Main masters index: 3 test, 2 boot seq, 1 data, 0 instruction.
  // DSP masters index: 1 modem DSP, 0 applications DSP.
  localparam ERR_IDLE = 3'b001;
  localparam ERR_FIRST = 3'b010;
  localparam ERR_SECOND = 3'b100;

  // Highest set bit wins; all-zero parks on bit 0
  function [MAIN_N-1:0] pick_main;
    input [MAIN_N-1:0] req;
    integer i;
    reg found;
    begin
      pick_main = {MAIN_N{1'b0}};
      found = 1'b0;
      for (i = MAIN_N - 1; i >= 0; i = i - 1) begin
        if (req[i] && !found) begin
          pick_main[i] = 1'b1;
          found = 1'b1;
        end
      end
      if (!found)
        pick_main[0] = 1'b1;
    end
  endfunction

  function [DSP_N-1:0] pick_dsp;
    input [DSP_N-1:0] req;
    integer i;
    reg found;
    begin
      pick_dsp = {DSP_N{1'b0}};
      found = 1'b0;
      for (i = DSP_N - 1; i >= 0; i = i - 1) begin
        if (req[i] && !found) begin
          pick_dsp[i] = 1'b1;
          found = 1'b1;
        end
      end
      if (!found)
        pick_dsp[0] = 1'b1;
    end
  endfunction

  // Strap synchroniser; first stage feeds only the second
  reg boot_s1_q, boot_s2_q, boot_s3_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_s1_q <= 1'b0;
      boot_s2_q <= 1'b0;
      boot_s3_q <= 1'b0;
      boot_nand_q <= 1'b0;
    end else begin
      boot_s1_q <= boot_mode_pin;
      boot_s2_q <= boot_s1_q;
      boot_s3_q <= boot_s2_q;
      if (boot_s2_q == boot_s3_q)
        boot_nand_q <= boot_s3_q;
    end
  end

  // Arbitration: regrant only on a ready cycle so bursts stay whole
  wire [MAIN_N-1:0] main_grant_d = pick_main(main_req);
  wire [DSP_N-1:0] dsp_grant_d = pick_dsp(dsp_req);
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_grant_q <= {{(MAIN_N-1){1'b0}}, 1'b1};
      dsp_grant_q <= {{(DSP_N-1){1'b0}}, 1'b1};
      gfx_grant_q <= 1'b0;
    end else begin
      if (main_hready_q)
        main_grant_q <= main_grant_d;
      if (dsp_hready_q)
        dsp_grant_q <= dsp_grant_d;
      gfx_grant_q <= 1'b1;
    end
  end

  // Decoders, one per layer
  wire [`NSEL-1:0] main_sel_d, dsp_sel_d, gfx_sel_d;
  layer_decoder #(.LAYER(`LAYER_MAIN)) u_dec_main (
    .haddr(main_haddr),
    .boot_nand(boot_nand_q),
    .sel(main_sel_d)
  );
  layer_decoder #(.LAYER(`LAYER_DSP)) u_dec_dsp (
    .haddr(dsp_haddr),
    .boot_nand(boot_nand_q),
    .sel(dsp_sel_d)
  );
  layer_decoder #(.LAYER(`LAYER_GFX)) u_dec_gfx (
    .haddr(gfx_haddr),
    .boot_nand(boot_nand_q),
    .sel(gfx_sel_d)
  );

  // Selects registered in the address phase, held over stalls
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_sel_q <= {`NSEL{1'b0}};
      dsp_sel_q <= {`NSEL{1'b0}};
      gfx_sel_q <= {`NSEL{1'b0}};
    end else begin
      if (main_hready_q)
        main_sel_q <= main_sel_d;
      if (dsp_hready_q)
        dsp_sel_q <= dsp_sel_d;
      if (gfx_hready_q)
        gfx_sel_q <= gfx_sel_d;
    end
  end

  // Default slave per layer: two-cycle error response
  wire [2:0] hit_err, slave_rdy, layer_rdy;
  wire [8:0] err_nxt;
  assign hit_err[0] = main_sel_d[`SEL_DEFAULT] &
    main_htrans[`HTRANS_ACTIVE_BIT];
  assign hit_err[1] = dsp_sel_d[`SEL_DEFAULT] &
    dsp_htrans[`HTRANS_ACTIVE_BIT];
  assign hit_err[2] = gfx_sel_d[`SEL_DEFAULT] &
    gfx_htrans[`HTRANS_ACTIVE_BIT];
  assign slave_rdy = {gfx_slave_hready, dsp_slave_hready, main_slave_hready};
  assign layer_rdy = {gfx_hready_q, dsp_hready_q, main_hready_q};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_err
      reg [2:0] state_q;
      reg [2:0] nxt;
      // A stalled hit waits; taking it early would lock the layer
      wire take_err = hit_err[g] & layer_rdy[g];
      always @* begin
        case (state_q)
          ERR_IDLE: nxt = take_err ? ERR_FIRST : ERR_IDLE;
          ERR_FIRST: nxt = ERR_SECOND;
          ERR_SECOND: nxt = take_err ? ERR_FIRST : ERR_IDLE;
          default: nxt = ERR_IDLE;
        endcase
      end
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
          state_q <= ERR_IDLE;
        else
          state_q <= nxt;
      end
      assign err_nxt[3*g +: 3] = nxt;
    end
  endgenerate

  // Ready and response: error slave overrides the addressed slave
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_hready_q <= 1'b1;
      dsp_hready_q <= 1'b1;
      gfx_hready_q <= 1'b1;
      main_hresp_q <= `HRESP_OKAY;
      dsp_hresp_q <= `HRESP_OKAY;
      gfx_hresp_q <= `HRESP_OKAY;
    end else begin
      main_hready_q <= err_nxt[2:0] == ERR_IDLE ? slave_rdy[0] :
        (err_nxt[2:0] == ERR_SECOND);
      dsp_hready_q <= err_nxt[5:3] == ERR_IDLE ? slave_rdy[1] :
        (err_nxt[5:3] == ERR_SECOND);
      gfx_hready_q <= err_nxt[8:6] == ERR_IDLE ? slave_rdy[2] :
        (err_nxt[8:6] == ERR_SECOND);
      main_hresp_q <= err_nxt[2:0] == ERR_IDLE ? `HRESP_OKAY : `HRESP_ERROR;
      dsp_hresp_q <= err_nxt[5:3] == ERR_IDLE ? `HRESP_OKAY : `HRESP_ERROR;
      gfx_hresp_q <= err_nxt[8:6] == ERR_IDLE ? `HRESP_OKAY : `HRESP_ERROR;
    end
  end
  // Endianness and halfword splitting live in the memory controllers
  // Burst kinds pass through untouched; slaves handle them
endmodule // multilayer_ahb_decode_arbitration

// ### test/ahb_decode_props_properties.sv
// Assertions on decode, error slave and arbitration outputs
`include "ahb_decode_map.vh"
module ahb_decode_props #(
  parameter MAIN_N = 4,
  parameter DSP_N = 2
) (
  input wire core_clk,
  input wire rst_n,
  input wire [MAIN_N-1:0] main_req,
  input wire [31:0] main_haddr,
  input wire [1:0] main_htrans,
  input wire [DSP_N-1:0] dsp_req,
  input wire [MAIN_N-1:0] main_grant_q,
  input wire [DSP_N-1:0] dsp_grant_q,
  input wire [`NSEL-1:0] main_sel_q,
  input wire [`NSEL-1:0] gfx_sel_q,
  input wire main_hready_q,
  input wire [1:0] main_hresp_q,
  input wire dsp_hready_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire take = main_hready_q && main_htrans[1];
  AST_ONE_SEL: assert property (take |=> $onehot(main_sel_q))
    else $error("main select not one-hot");
  AST_NO_MOTION: assert property (take && main_haddr[31:27] == 5'h0d
    |=> main_sel_q[`SEL_DEFAULT]) else $error("main reached motion unit");
  AST_GFX_NO_MOTION: assert property (!gfx_sel_q[`SEL_MOTION])
    else $error("graphics reached motion unit");
  AST_GAP_ERR: assert property (take && main_haddr[31:28] == 4'h7
    |=> !main_hready_q && main_hresp_q == `HRESP_ERROR
    ##1 main_hready_q && main_hresp_q == `HRESP_ERROR)
    else $error("gap access without two-cycle error");
  AST_GRANT_HOLD: assert property (!main_hready_q |=> $stable(main_grant_q))
    else $error("main grant moved while stalled");
  AST_MAIN_TOP: assert property (main_hready_q && main_req[3]
    |=> main_grant_q == 4'b1000) else $error("test master not granted");
  AST_MAIN_PARK: assert property (main_hready_q && main_req == 0
    |=> main_grant_q == 4'b0001) else $error("main grant not parked");
  AST_DSP_PRIO: assert property (dsp_hready_q && dsp_req[1]
    |=> dsp_grant_q == 2'b10) else $error("modem dsp not granted");
  AST_BOOT_SRAM: assert property (take && main_haddr[31:16] == 16'hffff
    |=> main_sel_q[`SEL_BOOT_SRAM]) else $error("boot sram not selected");
  cover property (take && main_haddr[31:28] == 4'h7);
  cover property (!main_hready_q && main_req[3]);
  cover property (take && main_haddr[31:16] == 16'hffff);
endmodule // ahb_decode_props
bind multilayer_ahb_decode_arbitration ahb_decode_props #(
  .MAIN_N(MAIN_N), .DSP_N(DSP_N)) i_ahb_decode_props (
  .core_clk(core_clk), .rst_n(rst_n), .main_req(main_req),
  .main_haddr(main_haddr), .main_htrans(main_htrans), .dsp_req(dsp_req),
  .main_grant_q(main_grant_q), .dsp_grant_q(dsp_grant_q),
  .main_sel_q(main_sel_q), .gfx_sel_q(gfx_sel_q),
  .main_hready_q(main_hready_q), .main_hresp_q(main_hresp_q),
  .dsp_hready_q(dsp_hready_q));

// ### test/slave_ready_model.sv
// Ready source standing in for the addressed slaves
module slave_ready_model (
  input wire core_clk,
  input wire rst_n,
  input wire stall_en,
  output logic hready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lfsr_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) lfsr_q <= 8'h5a;
    else lfsr_q <= {lfsr_q[6:0], ^(lfsr_q & 8'hb8)};
  end
  // Accepts every burst kind; waits vary each cycle when stalling
  assign hready = !stall_en || lfsr_q[0];
endmodule // slave_ready_model

// ### test/multilayer_ahb_decode_arbitration_tb.sv
// Self-checking bench for the layered decoder and arbiters
`include "ahb_decode_map.vh"
module multilayer_ahb_decode_arbitration_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int cyc; int kind; logic [16:0] val;} note_t;
  note_t q[$];
  string nm[10] = '{"main_sel", "dsp_sel", "gfx_sel", "main_grant",
    "dsp_grant", "boot_nand", "main_resp", "dsp_resp", "gfx_resp",
    "gfx_grant"};
  logic core_clk = 0, rst_n = 0, boot_mode_pin = 0, stall = 0;
  logic [3:0] main_req = 0;
  logic [1:0] dsp_req = 0;
  logic [31:0] haddr [3] = '{0, 0, 0};
  logic [1:0] htrans [3] = '{0, 0, 0};
  logic [31:0] seed = 32'h7e7b_49c0;
  wire [3:0] main_grant_q;
  wire [1:0] dsp_grant_q;
  wire [16:0] sel [3];
  wire [1:0] resp [3];
  wire rdy [3];
  wire srdy [3];
  wire gfx_grant_q, boot_nand_q;
  int bad_count = 0, tests_run = 0, cyc = 0, ticks = 0;
  always #25 core_clk = ~core_clk;
  for (genvar g = 0; g < 3; g++) begin : slaves
    slave_ready_model i_slave_ready_model (.core_clk(core_clk),
      .rst_n(rst_n), .stall_en(stall), .hready(srdy[g]));
  end
  multilayer_ahb_decode_arbitration i_multilayer_ahb_decode_arbitration (
    .core_clk(core_clk), .rst_n(rst_n), .boot_mode_pin(boot_mode_pin),
    .main_req(main_req), .main_haddr(haddr[0]), .main_htrans(htrans[0]),
    .dsp_req(dsp_req), .dsp_haddr(haddr[1]), .dsp_htrans(htrans[1]),
    .gfx_haddr(haddr[2]), .gfx_htrans(htrans[2]),
    .main_slave_hready(srdy[0]), .dsp_slave_hready(srdy[1]),
    .gfx_slave_hready(srdy[2]), .main_grant_q(main_grant_q),
    .dsp_grant_q(dsp_grant_q), .gfx_grant_q(gfx_grant_q),
    .main_sel_q(sel[0]), .dsp_sel_q(sel[1]), .gfx_sel_q(sel[2]),
    .main_hready_q(rdy[0]), .main_hresp_q(resp[0]),
    .dsp_hready_q(rdy[1]), .dsp_hresp_q(resp[1]),
    .gfx_hready_q(rdy[2]), .gfx_hresp_q(resp[2]),
    .boot_nand_q(boot_nand_q));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Layer 0 main, 1 dsp, 2 graphics
  function automatic logic [16:0] exp_sel(int l, logic [31:0] a, logic n);
    int b;
    b = `SEL_DEFAULT;
    if (a[31:27] < 5'h04) b = a[31:27] ^ {n, 1'b0};
    else if (a[31:27] <= 5'h0d) b = a[31:27];
    else if (a[31:27] == 5'h10) b = `SEL_LEGACY;
    if (a[31:16] == 16'hffff) b = `SEL_BOOT_SRAM;
    if (l == 0 && b == 13 || l > 0 && b > 8 && !(l == 1 && b == 13))
      b = `SEL_DEFAULT;
    return 17'h1 << b;
  endfunction
  function automatic logic [3:0] top1(logic [3:0] r);
    top1 = 4'b0001;
    for (int i = 0; i < 4; i++) if (r[i]) top1 = 4'b0001 << i;
  endfunction
  task automatic close_out();
    if (q.size() != 0) begin
      bad_count++;
      $display("[ERR] pending_notes expected 0 seen %0d", q.size());
    end
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Response noted as {ready, resp}: error slave is 001 then 101
  task automatic xfer(int l, logic [31:0] a);
    logic [16:0] e;
    e = exp_sel(l, a, boot_mode_pin);
    haddr[l] <= a;
    htrans[l] <= `HTRANS_NSEQ;
    q.push_back('{cyc + 1, l, e});
    q.push_back('{cyc + 1, 6 + l, e[`SEL_DEFAULT] ? 17'h1 : 17'h4});
    q.push_back('{cyc + 2, 6 + l, e[`SEL_DEFAULT] ? 17'h5 : 17'h4});
    @(posedge core_clk);
    htrans[l] <= `HTRANS_IDLE;
    repeat (3) @(posedge core_clk);
  endtask
  // Oldest note is compared once its cycle has settled
  always @(negedge core_clk) begin
    while (q.size() > 0 && q[0].cyc == cyc) begin
      logic [16:0] s;
      case (q[0].kind)
        0, 1, 2: s = sel[q[0].kind];
        3: s = 17'(main_grant_q);
        4: s = 17'(dsp_grant_q);
        5: s = 17'(boot_nand_q);
        9: s = 17'(gfx_grant_q);
        default: s = 17'({rdy[q[0].kind - 6], resp[q[0].kind - 6]});
      endcase
      tests_run++;
      if (s !== q[0].val) begin
        bad_count++;
        $display("[ERR] %s expected %h seen %h", nm[q[0].kind], q[0].val, s);
      end
      void'(q.pop_front());
    end
    cyc <= cyc + 1;
  end
  always @(posedge core_clk) begin
    ticks++;
    if (ticks == 5000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    logic [31:0] v;
    for (int n = 0; n < 2; n++) begin
      @(posedge core_clk);
      boot_mode_pin <= n[0];
      rst_n <= 0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1;
      repeat (8) @(posedge core_clk);
      q.push_back('{cyc + 1, 5, 17'(n)});
      q.push_back('{cyc + 1, 9, 17'h1});
      for (int l = 0; l < 3; l++) begin
        for (int r = 0; r < 32; r++) begin
          xfer(l, {r[4:0], 1'b0, 26'(rnd())});
        end
      end
      xfer(0, {16'hffff, 16'(rnd())});
      xfer(0, 32'hfffe_ffff);
    end
    for (int r = 0; r < 16; r++) begin
      main_req <= r[3:0];
      dsp_req <= r[1:0];
      q.push_back('{cyc + 1, 3, 17'(top1(r[3:0]))});
      q.push_back('{cyc + 1, 4, r[1] ? 17'h2 : 17'h1});
      @(posedge core_clk);
    end
    stall <= 1;
    repeat (200) begin
      v = rnd();
      dsp_req <= v[1:0];
      if (rdy[0]) begin
        main_req <= v[7:4];
        htrans[0] <= {v[8], 1'b0};
        haddr[0] <= rnd();
      end
      @(posedge core_clk);
    end
    htrans[0] <= `HTRANS_IDLE;
    repeat (4) @(posedge core_clk);
    close_out();
  end
endmodule // multilayer_ahb_decode_arbitration_tb
